// ### include/mrs_cfg.svh
// Constants for the multi-reference clock selector: offsets, fields, resets and timing.
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
`define NUM_SRC 7
`define CLK_HZ 200000000
`define CYCLES_PER_SEC (`CLK_HZ)
`define FREQ_OUT_HZ 10000000
`define FREQ_HALF_CYCLES (`CLK_HZ / (2 * `FREQ_OUT_HZ))
`define PTP_POLL_S 10
`define NTP_POLL_S 64
`define LOCK_SECS 2
`define FINE_LIMIT 32'h0000_0010
`define OSC_CONST_RST 16'h0072
`define OSC_CONST_DIV 36'h0_0000_000A
`define CABLE_NS_PER_M 32'h0000_0005
`define PRIO_RST 21'h1A_C688
`define REG_CTRL 12'h000
`define REG_PRIO 12'h004
`define REG_STATUS 12'h008
`define REG_HOLD_REM 12'h00C
`define REG_HOLD_TOT 12'h010
`define REG_OSC_CONST 12'h014
`define REG_NTP_SEL 12'h018
`define REG_CABLE 12'h01C
`define REG_OFFSET 12'h040
`define REG_PREC 12'h080
`define REG_DEV 12'h0C0
`define ST_MASTER 0
`define ST_MASTER_VALID 3
`define ST_UNSYNC 4
`define ST_STEPPED 5
`define ST_FREE_RUN 6
`define ST_HOLDOVER 7
`define ST_AVAIL 8
`define SRC_GNSS 3'h0
`define SRC_NTP 3'h1
`define SRC_PTP 3'h2
`endif

// ### include/mrs_pkg.sv
// Types shared by the multi-reference clock selector.
package mrs_pkg;
    typedef enum logic [2:0] {
        FREE_RUN,
        CHANGEOVER,
        LOCKED,
        HOLDOVER
    } selState_t;
    typedef logic [2:0] srcId_t;
endpackage

// ### verif/mrs_checker.sv
// Concurrent checks on the timing outputs of the multi-reference clock selector.
`include "mrs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mrs_checker #(
    parameter int CyclesPerSec = 50,
    parameter logic [31:0] FineLimit = `FINE_LIMIT
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Observed pins.
    input wire logic [`NUM_SRC-1:0] refSyncPin,
    input wire logic steerStrobe,
    input wire logic coarseStep,
    input wire logic [31:0] steerValue,
    input wire logic secondTick,
    input wire logic ptpPoll,
    input wire logic ntpPoll,
    input wire logic freqOut,
    input wire logic refUnsync
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic stepped_r;
    logic ticked_r;
    int cyc_r;
    int ptpTicks_r;
    int ntpTicks_r;
    // Event history; poll counters restart at each poll so every interval is judged alone.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stepped_r <= 1'b0;
            ticked_r <= 1'b0;
            cyc_r <= 0;
            ptpTicks_r <= 0;
            ntpTicks_r <= 0;
        end else begin
            stepped_r <= stepped_r | coarseStep;
            ticked_r <= ticked_r | secondTick;
            cyc_r <= secondTick ? 1 : cyc_r + 1;
            ptpTicks_r <= ptpPoll ? 0 : ptpTicks_r + int'(secondTick);
            ntpTicks_r <= ntpPoll ? 0 : ntpTicks_r + int'(secondTick);
        end
    end
    sequence halfWave;
        $stable(freqOut) [*8] ##1 $stable(freqOut) ##1 $changed(freqOut);
    endsequence
    sequence noRefs;
        (refSyncPin == '0) [*6];
    endsequence
    coarse_once_a: assert property (coarseStep |-> steerStrobe && !stepped_r)
        else $error("coarse step repeated or without strobe");
    steer_tick_a: assert property (steerStrobe |-> $past(secondTick))
        else $error("steer strobe not after a second tick");
    fine_step_a: assert property (steerStrobe && !coarseStep |-> ($signed(steerValue) <= $signed(FineLimit))
        && ($signed(steerValue) >= -$signed(FineLimit)))
        else $error("fine step beyond limit");
    tick_period_a: assert property (secondTick && ticked_r |-> cyc_r == CyclesPerSec)
        else $error("second tick period wrong");
    ptp_poll_a: assert property (ptpPoll |-> ptpTicks_r == `PTP_POLL_S)
        else $error("PTP poll interval wrong");
    ntp_poll_a: assert property (ntpPoll |-> ntpTicks_r == `NTP_POLL_S)
        else $error("NTP poll interval wrong");
    freq_wave_a: assert property ($changed(freqOut) |=> halfWave)
        else $error("frequency output half period wrong");
    free_run_a: assert property (noRefs |-> refUnsync)
        else $error("synchronized without any reference");
endmodule // mrs_checker
bind multi_reference_clock_selector mrs_checker #(.CyclesPerSec(CyclesPerSec), .FineLimit(FineLimit)) u_chk (
    .clk(clk), .rst_b(rst_b), .refSyncPin(refSyncPin), .steerStrobe(steerStrobe), .coarseStep(coarseStep),
    .steerValue(steerValue), .secondTick(secondTick), .ptpPoll(ptpPoll), .ntpPoll(ntpPoll),
    .freqOut(freqOut), .refUnsync(refUnsync));
`default_nettype wire

// ### verif/multi_reference_clock_selector_tb.sv
// Self-checking bench for the multi-reference clock selector.
`include "mrs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module multi_reference_clock_selector_tb;
    localparam int Cps = 50;
    typedef struct packed {logic [11:0] addr; logic wr; logic [31:0] data;} row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [6:0] syncReq = 7'h00;
    logic [6:0] ntpUp = 7'h00;
    logic hreadyout, hresp, ptpPoll, ntpPoll, steerStrobe, coarseStep, secondTick, ppsOut, freqOut, refUnsync;
    logic [31:0] hrdata, steerValue, ptpDeviation, rd;
    logic [6:0] refSyncPin, ntpServerValid;
    logic [7*32-1:0] refDeviation, ntpServerDev;
    logic [7*16-1:0] ntpServerJitter;
    int err_count = 0;
    int checks = 0;
    // Register cases: a read row holds the value expected back.
    row_t rows [14] = '{'{`REG_PRIO, 1'b0, 32'h001A_C688}, '{`REG_PRIO, 1'b1, 32'h0000_0000},
        '{`REG_PRIO, 1'b0, 32'h0000_0000}, '{`REG_PRIO, 1'b1, 32'h001A_C688},
        '{`REG_OSC_CONST, 1'b0, 32'h0000_0072}, '{`REG_OFFSET, 1'b1, 32'h0000_0007},
        '{`REG_OFFSET, 1'b0, 32'h0000_0000}, '{`REG_OFFSET + 12'h00C, 1'b1, 32'h0000_0005},
        '{`REG_OFFSET + 12'h00C, 1'b0, 32'h0000_0005}, '{`REG_CABLE, 1'b1, 32'h0000_000A},
        '{12'h100, 1'b1, 32'h0000_0001}, '{12'h100, 1'b0, 32'h0000_0000},
        '{`REG_DEV + 12'h00C, 1'b0, 32'h0000_0195}, '{`REG_DEV, 1'b0, 32'h0000_0096}};
    multi_reference_clock_selector #(.CyclesPerSec(Cps)) u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .refSyncPin(refSyncPin), .refDeviation(refDeviation),
        .ptpDeviation(ptpDeviation), .ntpServerValid(ntpServerValid), .ntpServerDev(ntpServerDev),
        .ntpServerJitter(ntpServerJitter), .ptpPoll(ptpPoll), .ntpPoll(ntpPoll), .steerStrobe(steerStrobe),
        .coarseStep(coarseStep), .steerValue(steerValue), .secondTick(secondTick), .ppsOut(ppsOut),
        .freqOut(freqOut), .refUnsync(refUnsync));
    ref_sources u_ref (.clk(clk), .syncReq(syncReq), .ntpUp(ntpUp), .refSyncPin(refSyncPin),
        .refDeviation(refDeviation), .ptpDeviation(ptpDeviation), .ntpServerValid(ntpServerValid),
        .ntpServerDev(ntpServerDev), .ntpServerJitter(ntpServerJitter));
    // Clock at 200 MHz.
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One single AHB transfer; the value just before each edge is what that edge samples.
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic waitMaster(input logic [2:0] m);
        logic [31:0] s;
        for (int i = 0; i < 60; i++) begin
            bus(`REG_STATUS, 1'b0, 32'h0000_0000, s);
            if (s[2:0] === m && s[3] === 1'b1) break;
        end
        chk("master", {29'h0, m}, {29'h0, s[2:0]});
    endtask
    task automatic waitLock();
        for (int i = 0; i < 200 && refUnsync !== 1'b0; i++) @(posedge clk);
        chk("refUnsync", 32'h0000_0000, 32'(refUnsync));
    endtask
    task automatic conclude();
        $display("Checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog sized well past the longest wait, the first NTP poll.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk("refUnsync", 32'h0000_0001, 32'(refUnsync));
        foreach (rows[i]) begin
            bus(rows[i].addr, rows[i].wr, rows[i].data, rd);
            if (!rows[i].wr) chk("register", rows[i].data, rd);
        end
        bus(`REG_STATUS, 1'b0, 32'h0000_0000, rd);
        chk("status", 32'h0000_0050, rd & 32'h0000_00F8);
        // Higher rank first, then a better one must take over at once.
        syncReq <= 7'h10;
        waitMaster(3'h4);
        syncReq <= 7'h18;
        waitMaster(3'h3);
        waitLock();
        bus(`REG_STATUS, 1'b0, 32'h0000_0000, rd);
        chk("stepped", 32'h0000_0020, rd & 32'h0000_0020);
        // Precisions are still zero, so the loss switches with no holdover.
        syncReq <= 7'h10;
        waitMaster(3'h4);
        bus(`REG_PREC + 12'h00C, 1'b1, 32'h0000_0064, rd);
        bus(`REG_PREC + 12'h010, 1'b1, 32'h0000_2710, rd);
        syncReq <= 7'h18;
        waitMaster(3'h3);
        waitLock();
        syncReq <= 7'h10;
        repeat (8) @(posedge clk);
        bus(`REG_HOLD_TOT, 1'b0, 32'h0000_0000, rd);
        chk("holdover total", 32'h0000_0474, rd);
        bus(`REG_HOLD_REM, 1'b0, 32'h0000_0000, rd);
        chk("holdover remaining", 32'h0000_0001, 32'(rd >= 32'h0000_0473 && rd <= 32'h0000_0474));
        // Regain, change the next source's precision, lose again: the total must follow.
        syncReq <= 7'h18;
        waitLock();
        bus(`REG_PREC + 12'h010, 1'b1, 32'h0000_4E20, rd);
        syncReq <= 7'h10;
        repeat (8) @(posedge clk);
        bus(`REG_HOLD_TOT, 1'b0, 32'h0000_0000, rd);
        chk("holdover total", 32'h0000_08E8, rd);
        // Servers 1, 2 and 5 valid; server 5 has the lowest jitter among them.
        ntpUp <= 7'h26;
        for (int i = 0; i < 70 * Cps && ntpPoll !== 1'b1; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        bus(`REG_NTP_SEL, 1'b0, 32'h0000_0000, rd);
        chk("ntp server", 32'h0000_000D, rd & 32'h0000_000F);
        chk("hresp", 32'h0000_0000, 32'(hresp));
        while (secondTick !== 1'b1) @(posedge clk);
        @(posedge clk);
        chk("pps", 32'h0000_0001, 32'(ppsOut));
        repeat (20) @(posedge clk);
        chk("pps", 32'h0000_0000, 32'(ppsOut));
        conclude();
    end
endmodule // multi_reference_clock_selector_tb
`default_nettype wire

// ### verif/ref_sources.sv
// Behavioural model of the external time references feeding the selector.
`include "mrs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ref_sources (
    // Clock and requests from the bench.
    input wire logic clk,
    input wire logic [`NUM_SRC-1:0] syncReq,
    input wire logic [6:0] ntpUp,
    // Reference side.
    output logic [`NUM_SRC-1:0] refSyncPin,
    output logic [`NUM_SRC*32-1:0] refDeviation,
    output logic [31:0] ptpDeviation,
    output logic [6:0] ntpServerValid,
    output logic [7*32-1:0] ntpServerDev,
    output logic [7*16-1:0] ntpServerJitter
);
    // Lock flags follow the request one cycle late, as a receiver reports lock.
    always_ff @(posedge clk) begin
        refSyncPin <= syncReq;
        ntpServerValid <= ntpUp;
    end
    // Small fixed deviations keep every source inside the startup window.
    // Server 6 has the lowest jitter but is never valid, so validity must win.
    always_comb begin
        for (int s = 0; s < 7; s++) begin
            refDeviation[s*32+:32] = 32'(100 * (s + 1));
            ntpServerDev[s*32+:32] = 32'(10 * s);
            ntpServerJitter[s*16+:16] = 16'(s == 6 ? 1 : (s == 5 ? 3 : 40 - s));
        end
        ptpDeviation = 32'h0000_0040;
    end
endmodule // ref_sources
`default_nettype wire

// ### verilog/multi_reference_clock_selector.sv
// Reference-source selection and disciplining control with an AHB-Lite register slave.
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`include "mrs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module multi_reference_clock_selector #(
    parameter int NumNtp = 7,
    parameter int CyclesPerSec = `CYCLES_PER_SEC,
    parameter int LockSecs = `LOCK_SECS,
    parameter int PpsHighCycles = 20,
    parameter logic [31:0] FineLimit = `FINE_LIMIT
) (
    // Oscillator clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Reference inputs: sync pins and measured deviations.
    input wire logic [`NUM_SRC-1:0] refSyncPin,
    input wire logic [`NUM_SRC*32-1:0] refDeviation,
    // PTP timestamping unit.
    input wire logic [31:0] ptpDeviation,
    // External NTP server measurements.
    input wire logic [NumNtp-1:0] ntpServerValid,
    input wire logic [NumNtp*32-1:0] ntpServerDev,
    input wire logic [NumNtp*16-1:0] ntpServerJitter,
    // Polling strobes.
    output logic ptpPoll,
    output logic ntpPoll,
    // Oscillator steering.
    output logic steerStrobe,
    output logic coarseStep,
    output logic [31:0] steerValue,
    // Derived time outputs.
    output logic secondTick,
    output logic ppsOut,
    output logic freqOut,
    output logic refUnsync
);
    // Reset released through two flops; assertion stays asynchronous.
    logic rstMeta_b;
    logic rstSync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_b <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_b <= 1'b1;
            rstSync_b <= rstMeta_b;
        end
    end

    // Sync pins come from outside; two flops before use.
    logic [`NUM_SRC-1:0] syncMeta_r;
    logic [`NUM_SRC-1:0] syncPin_r;
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            syncMeta_r <= '0;
            syncPin_r <= '0;
        end else begin
            syncMeta_r <= refSyncPin;
            syncPin_r <= syncMeta_r;
        end
    end

    // Configuration and state registers.
    logic [20:0] prio_r;
    logic [15:0] oscConst_r;
    logic [31:0] cable_r;
    logic [31:0] offset_r [`NUM_SRC];
    logic [31:0] prec_r [`NUM_SRC];
    logic [31:0] ptpDev_r;
    logic [31:0] ntpDev_r;
    logic [2:0] ntpSel_r;
    logic ntpSelValid_r;
    mrs_pkg::selState_t state_r;
    mrs_pkg::srcId_t master_r;
    logic stepped_r;
    logic holdCalc_r;
    logic [31:0] holdRem_r;
    logic [31:0] holdTot_r;
    logic [31:0] lockCnt_r;

    // Rank of a source in the priority table; rank 0 is the most trusted.
    function automatic logic [2:0] rankOf(input logic [20:0] prio, input logic [2:0] src);
        logic [2:0] r;
        r = 3'h7;
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            if (prio[i*3 +: 3] == src) begin
                r = i[2:0];
            end
        end
        return r;
    endfunction

    // Holdover seconds; a zero precision on either side means no delay.
    function automatic logic [31:0] holdSecs(input logic [31:0] nxt, input logic [31:0] cur,
                                              input logic [15:0] k);
        logic [47:0] num;
        logic [47:0] den;
        logic [47:0] q;
        num = {16'h0000, nxt} * {32'h0000_0000, k};
        den = {12'h000, {4'h0, cur} * `OSC_CONST_DIV};
        q = '0;
        if (nxt != 32'h0000_0000 && cur != 32'h0000_0000) begin
            q = num / den;
        end
        return (q[47:32] != 16'h0000) ? 32'hFFFF_FFFF : q[31:0];
    endfunction

    // Availability per source; NTP also needs a chosen server.
    logic [`NUM_SRC-1:0] avail;
    always_comb begin
        avail = syncPin_r;
        avail[`SRC_NTP] = syncPin_r[`SRC_NTP] & ntpSelValid_r;
    end

    // Raw deviation per source plus its fixed offset or cable delay.
    logic [31:0] devSum [`NUM_SRC];
    always_comb begin
        for (int s = 0; s < `NUM_SRC; s++) begin
            devSum[s] = refDeviation[s*32 +: 32] + offset_r[s];
        end
        devSum[`SRC_NTP] = ntpDev_r + offset_r[`SRC_NTP];
        devSum[`SRC_PTP] = ptpDev_r + offset_r[`SRC_PTP];
        devSum[`SRC_GNSS] = refDeviation[31:0] + cable_r * `CABLE_NS_PER_M;
    end

    // Best available source: lowest rank wins, scanning from the bottom up.
    mrs_pkg::srcId_t best;
    logic bestValid;
    logic [2:0] bestRank;
    logic [2:0] masterRank;
    always_comb begin
        best = '0;
        bestValid = 1'b0;
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            if (avail[prio_r[i*3 +: 3]]) begin
                best = prio_r[i*3 +: 3];
                bestValid = 1'b1;
            end
        end
        bestRank = rankOf(prio_r, best);
        masterRank = rankOf(prio_r, master_r);
    end

    // Time base: the only clock is the oscillator, so every output follows it.
    logic [31:0] secCnt_r;
    logic [7:0] halfCnt_r;
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            secCnt_r <= '0;
            secondTick <= 1'b0;
            ppsOut <= 1'b0;
            halfCnt_r <= '0;
            freqOut <= 1'b0;
        end else begin
            secondTick <= (secCnt_r == 32'(CyclesPerSec - 1));
            secCnt_r <= (secCnt_r == 32'(CyclesPerSec - 1)) ? 32'h0000_0000 : secCnt_r + 32'h0000_0001;
            ppsOut <= (secCnt_r < 32'(PpsHighCycles));
            if (halfCnt_r == 8'(`FREQ_HALF_CYCLES - 1)) begin
                halfCnt_r <= '0;
                freqOut <= ~freqOut;
            end else begin
                halfCnt_r <= halfCnt_r + 8'h01;
            end
        end
    end

    // Poll timers count whole seconds, apart from any PTP message rate.
    logic [5:0] ptpSec_r;
    logic [6:0] ntpSec_r;
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ptpSec_r <= '0;
            ntpSec_r <= '0;
            ptpPoll <= 1'b0;
            ntpPoll <= 1'b0;
        end else begin
            ptpPoll <= secondTick && (ptpSec_r == 6'(`PTP_POLL_S - 1));
            ntpPoll <= secondTick && (ntpSec_r == 7'(`NTP_POLL_S - 1));
            if (secondTick) begin
                ptpSec_r <= (ptpSec_r == 6'(`PTP_POLL_S - 1)) ? 6'h00 : ptpSec_r + 6'h01;
                ntpSec_r <= (ntpSec_r == 7'(`NTP_POLL_S - 1)) ? 7'h00 : ntpSec_r + 7'h01;
            end
        end
    end

    // Lowest-jitter valid NTP server; ties go to the lower index.
    logic [2:0] ntpPick;
    logic ntpPickValid;
    logic [15:0] ntpPickJit;
    always_comb begin
        ntpPick = '0;
        ntpPickValid = 1'b0;
        ntpPickJit = 16'hFFFF;
        for (int n = 0; n < NumNtp; n++) begin
            if (ntpServerValid[n] && (!ntpPickValid || ntpServerJitter[n*16 +: 16] < ntpPickJit)) begin
                ntpPick = n[2:0];
                ntpPickValid = 1'b1;
                ntpPickJit = ntpServerJitter[n*16 +: 16];
            end
        end
    end

    // PTP and NTP deviations are latched only at their polls, so selection never sees a half update.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ptpDev_r <= '0;
            ntpDev_r <= '0;
            ntpSel_r <= '0;
            ntpSelValid_r <= 1'b0;
        end else begin
            if (ptpPoll) begin
                ptpDev_r <= ptpDeviation;
            end
            if (ntpPoll) begin
                ntpSel_r <= ntpPick;
                ntpSelValid_r <= ntpPickValid;
                ntpDev_r <= ntpServerDev[ntpPick*32 +: 32];
            end
        end
    end

    // Master selection, changeover and holdover.
    logic [31:0] holdNew;
    assign holdNew = holdSecs(prec_r[best], prec_r[master_r], oscConst_r);
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_r <= mrs_pkg::FREE_RUN;
            master_r <= '0;
            holdCalc_r <= 1'b0;
            holdRem_r <= '0;
            holdTot_r <= '0;
            lockCnt_r <= '0;
        end else begin
            case (state_r)
                mrs_pkg::FREE_RUN: begin
                    if (bestValid) begin
                        master_r <= best;
                        lockCnt_r <= '0;
                        state_r <= mrs_pkg::CHANGEOVER;
                    end
                end
                mrs_pkg::CHANGEOVER: begin
                    if (bestValid && bestRank < masterRank) begin
                        master_r <= best;
                        lockCnt_r <= '0;
                    end else if (!avail[master_r]) begin
                        holdCalc_r <= 1'b0;
                        state_r <= mrs_pkg::HOLDOVER;
                    end else if (lockCnt_r >= 32'(LockSecs)) begin
                        state_r <= mrs_pkg::LOCKED;
                    end else if (secondTick) begin
                        lockCnt_r <= lockCnt_r + 32'h0000_0001;
                    end
                end
                mrs_pkg::LOCKED: begin
                    if (bestValid && bestRank < masterRank) begin
                        master_r <= best;
                        lockCnt_r <= '0;
                        state_r <= mrs_pkg::CHANGEOVER;
                    end else if (!avail[master_r]) begin
                        holdCalc_r <= 1'b0;
                        state_r <= mrs_pkg::HOLDOVER;
                    end
                end
                mrs_pkg::HOLDOVER: begin
                    if (avail[master_r]) begin
                        state_r <= mrs_pkg::LOCKED;
                    end else if (bestValid && bestRank < masterRank) begin
                        master_r <= best;
                        lockCnt_r <= '0;
                        state_r <= mrs_pkg::CHANGEOVER;
                    end else if (!holdCalc_r && bestValid) begin
                        holdTot_r <= holdNew;
                        holdRem_r <= holdNew;
                        holdCalc_r <= 1'b1;
                        if (holdNew == 32'h0000_0000) begin
                            master_r <= best;
                            lockCnt_r <= '0;
                            state_r <= mrs_pkg::CHANGEOVER;
                        end
                    end else if (holdCalc_r && !bestValid) begin
                        holdCalc_r <= 1'b0;
                    end else if (holdCalc_r && secondTick) begin
                        if (holdRem_r <= 32'h0000_0001) begin
                            holdRem_r <= '0;
                            master_r <= best;
                            lockCnt_r <= '0;
                            state_r <= mrs_pkg::CHANGEOVER;
                        end else begin
                            holdRem_r <= holdRem_r - 32'h0000_0001;
                        end
                    end
                end
                default: begin
                    state_r <= mrs_pkg::FREE_RUN;
                end
            endcase
        end
    end

    // Reference time counts as unsynchronized outside the locked state.
    assign refUnsync = (state_r != mrs_pkg::LOCKED);

    // Steering once per second from the master only; first sample steps, later ones are clamped.
    logic steerNow;
    logic [31:0] err;
    assign steerNow = secondTick && avail[master_r] &&
                      (state_r == mrs_pkg::CHANGEOVER || state_r == mrs_pkg::LOCKED);
    assign err = devSum[master_r];
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            stepped_r <= 1'b0;
            steerStrobe <= 1'b0;
            coarseStep <= 1'b0;
            steerValue <= '0;
        end else begin
            steerStrobe <= steerNow;
            coarseStep <= steerNow && !stepped_r;
            if (steerNow) begin
                stepped_r <= 1'b1;
                if (!stepped_r) begin
                    steerValue <= err;
                end else if ($signed(err) > $signed(FineLimit)) begin
                    steerValue <= FineLimit;
                end else if ($signed(err) < -$signed(FineLimit)) begin
                    steerValue <= -FineLimit;
                end else begin
                    steerValue <= err;
                end
            end
        end
    end

    // AHB-Lite address phase capture; the slave never inserts wait states.
    logic wrPend_r;
    logic [11:0] wrAddr_r;
    logic [31:0] rdNxt;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= '0;
            hrdata <= '0;
        end else if (hready) begin
            wrPend_r <= hsel && htrans[1] && hwrite;
            wrAddr_r <= haddr;
            hrdata <= (hsel && htrans[1] && !hwrite) ? rdNxt : 32'h0000_0000;
        end
    end

    // Read decode; unmapped addresses read zero.
    always_comb begin
        rdNxt = 32'h0000_0000;
        case (haddr)
            `REG_PRIO: rdNxt = {11'h000, prio_r};
            `REG_STATUS: begin
                rdNxt[`ST_MASTER +: 3] = master_r;
                rdNxt[`ST_MASTER_VALID] = (state_r != mrs_pkg::FREE_RUN);
                rdNxt[`ST_UNSYNC] = refUnsync;
                rdNxt[`ST_STEPPED] = stepped_r;
                rdNxt[`ST_FREE_RUN] = (state_r == mrs_pkg::FREE_RUN);
                rdNxt[`ST_HOLDOVER] = (state_r == mrs_pkg::HOLDOVER);
                rdNxt[`ST_AVAIL +: `NUM_SRC] = avail;
            end
            `REG_HOLD_REM: rdNxt = holdRem_r;
            `REG_HOLD_TOT: rdNxt = holdTot_r;
            `REG_OSC_CONST: rdNxt = {16'h0000, oscConst_r};
            `REG_NTP_SEL: rdNxt = {28'h000_0000, ntpSelValid_r, ntpSel_r};
            `REG_CABLE: rdNxt = cable_r;
            default: begin
                for (int s = 0; s < `NUM_SRC; s++) begin
                    if (haddr == `REG_OFFSET + 12'(s * 4)) begin
                        rdNxt = offset_r[s];
                    end
                    if (haddr == `REG_PREC + 12'(s * 4)) begin
                        rdNxt = prec_r[s];
                    end
                    if (haddr == `REG_DEV + 12'(s * 4)) begin
                        rdNxt = devSum[s];
                    end
                end
            end
        endcase
    end

    // Writes land in the data phase; the satellite offset slot stays zero.
    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            prio_r <= `PRIO_RST;
            oscConst_r <= `OSC_CONST_RST;
            cable_r <= '0;
            for (int s = 0; s < `NUM_SRC; s++) begin
                offset_r[s] <= '0;
                prec_r[s] <= '0;
            end
        end else if (wrPend_r) begin
            if (wrAddr_r == `REG_PRIO) begin
                prio_r <= hwdata[20:0];
            end
            if (wrAddr_r == `REG_OSC_CONST) begin
                oscConst_r <= hwdata[15:0];
            end
            if (wrAddr_r == `REG_CABLE) begin
                cable_r <= hwdata;
            end
            for (int s = 1; s < `NUM_SRC; s++) begin
                if (wrAddr_r == `REG_OFFSET + 12'(s * 4)) begin
                    offset_r[s] <= hwdata;
                end
            end
            for (int s = 0; s < `NUM_SRC; s++) begin
                if (wrAddr_r == `REG_PREC + 12'(s * 4)) begin
                    prec_r[s] <= hwdata;
                end
            end
        end
    end

    // Only full-word transfers are expected; hsize is accepted but not checked.
    logic unusedSize;
    assign unusedSize = ^hsize;
endmodule // multi_reference_clock_selector
`default_nettype wire
